// ===== hw/pbsi_top.v
// processor bus strobe interface with axi4-lite control registers
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "pbsi_defs.vh"
module pbsi_top (
  // clock and reset
  input wire clk,
  input wire nrst,
  // processor bus
  input wire [15:0] infoBusIn,
  output reg [15:0] infoBusOut,
  output reg infoBusOe,
  input wire parityBitLineIn,
  output reg parityBitLineOut,
  output reg parityBitLineOe,
  input wire addrLatchStrobe,
  input wire dataStrobeN,
  input wire memIoSel,
  input wire readWriteSel,
  // address outputs and extended address inputs
  output reg [15:0] addrOut,
  output reg [15:0] addrOe,
  input wire [1:0] extAddrIn,
  // strobes
  input wire strobeDriveEnableN,
  output reg memWriteStrobeN,
  output reg memReadStrobeN,
  output reg ioWriteStrobeN,
  output reg ioReadStrobeN,
  output reg strobeOe,
  output reg irqAckStrobeN,
  output reg configReadStrobeN,
  // system
  input wire extReadyIn,
  output reg cycleReady,
  input wire testEnableN,
  output reg selfTestDone,
  output reg bootRomSelect,
  input wire [4:0] sysConfigIn,
  // axi4-lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ************************************
  // state
  // ************************************
  localparam ST_IDLE = 3'b001;
  localparam ST_TEST = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [15:0] testCnt_reg;
  reg testReq_reg;
  reg [15:0] latchAddr_reg;
  reg [3:0] ctrl_reg;
  reg [19:0] wait_reg;
  reg [3:0] waitCnt_reg;
  reg paritySample_reg;
  reg [3:0] awAddr_reg;
  reg awHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg wHeld_reg;

  // ************************************
  // cycle decode
  // ************************************
  wire active = ~dataStrobeN;
  wire isRead = readWriteSel;
  wire memCyc = active & memIoSel;
  wire ioCyc = active & ~memIoSel;
  wire hitIrqAck = ioCyc & ~isRead & (latchAddr_reg == `PBSI_IO_IRQ_ACK);
  wire hitConf = ioCyc & isRead & (latchAddr_reg == `PBSI_IO_CONF);
  wire hitSurOn = ioCyc & ~isRead & (latchAddr_reg == `PBSI_IO_SURON);
  wire hitSurOff = ioCyc & ~isRead & (latchAddr_reg == `PBSI_IO_SUROFF);
  wire internalIo = hitIrqAck | hitConf | hitSurOn | hitSurOff;
  wire testing = state_reg == ST_TEST;
  wire mmuOn = ctrl_reg[`PBSI_CTRL_MMU];
  wire floatStrb = strobeDriveEnableN & ctrl_reg[`PBSI_CTRL_STRB_FLT];
  wire floatAddr = strobeDriveEnableN & ctrl_reg[`PBSI_CTRL_ADDR_FLT];

  // selected wait count for this cycle
  reg [3:0] waitSel;
  always @* begin
    if (~memIoSel) begin
      waitSel = wait_reg[`PBSI_WAIT_IO +: `PBSI_WAIT_W];
    end else if (mmuOn) begin
      waitSel = wait_reg[extAddrIn * `PBSI_WAIT_W +: `PBSI_WAIT_W];
    end else begin
      waitSel = wait_reg[0 +: `PBSI_WAIT_W];
    end
  end

  // ************************************
  // self test sequencer
  // ************************************
  always @* begin
    case (state_reg)
      ST_IDLE: begin
        state_next = testReq_reg ? ST_TEST : ST_RUN;
      end
      ST_TEST: begin
        state_next = (testCnt_reg == `PBSI_TEST_CYC) ? ST_RUN : ST_TEST;
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      testReq_reg <= ~testEnableN;
      testCnt_reg <= 16'h0000;
      selfTestDone <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (testing) begin
        testCnt_reg <= testCnt_reg + 16'h0001;
      end
      selfTestDone <= (state_next == ST_RUN);
    end
  end

  // ************************************
  // address latch and outputs
  // ************************************
  always @(posedge clk) begin
    if (!nrst) begin
      latchAddr_reg <= 16'h0000;
      addrOut <= 16'h0000;
      addrOe <= 16'h0000;
    end else begin
      if (addrLatchStrobe) begin
        latchAddr_reg <= infoBusIn;
      end
      addrOut <= latchAddr_reg;
      if (floatAddr) begin
        addrOe <= 16'h0000;
      end else if (mmuOn & memIoSel) begin
        addrOe <= 16'hFFF0;
      end else begin
        addrOe <= 16'hFFFF;
      end
    end
  end

  // ************************************
  // strobes
  // ************************************
  always @(posedge clk) begin
    if (!nrst) begin
      memWriteStrobeN <= 1'b1;
      memReadStrobeN <= 1'b1;
      ioWriteStrobeN <= 1'b1;
      ioReadStrobeN <= 1'b1;
      strobeOe <= 1'b0;
      irqAckStrobeN <= 1'b1;
      configReadStrobeN <= 1'b1;
      bootRomSelect <= 1'b1;
    end else begin
      // strobes follow the data strobe
      memWriteStrobeN <= ~(memCyc & ~isRead);
      memReadStrobeN <= ~(memCyc & isRead);
      ioWriteStrobeN <= ~(ioCyc & ~isRead);
      ioReadStrobeN <= ~(ioCyc & isRead);
      strobeOe <= ~floatStrb;
      irqAckStrobeN <= ~hitIrqAck;
      configReadStrobeN <= ~hitConf;
      if (hitSurOn) begin
        bootRomSelect <= 1'b1;
      end else if (hitSurOff) begin
        bootRomSelect <= 1'b0;
      end
    end
  end

  // ************************************
  // information bus and parity
  // ************************************
  always @(posedge clk) begin
    if (!nrst) begin
      infoBusOut <= 16'h0000;
      infoBusOe <= 1'b0;
      parityBitLineOut <= 1'b0;
      parityBitLineOe <= 1'b0;
      paritySample_reg <= 1'b0;
    end else begin
      infoBusOut <= {11'h000, sysConfigIn};
      infoBusOe <= hitConf;
      parityBitLineOut <= ^infoBusIn ^ ctrl_reg[`PBSI_CTRL_ODD];
      parityBitLineOe <= active & ~isRead;
      if (active & isRead) begin
        paritySample_reg <= parityBitLineIn;
      end
    end
  end

  // ************************************
  // ready generation
  // ************************************
  always @(posedge clk) begin
    if (!nrst) begin
      waitCnt_reg <= 4'h0;
      cycleReady <= 1'b0;
    end else begin
      if (active) begin
        if (waitCnt_reg != 4'hF) begin
          waitCnt_reg <= waitCnt_reg + 4'h1;
        end
      end else begin
        waitCnt_reg <= 4'h0;
      end
      cycleReady <= extReadyIn & active &
        (testing | internalIo | (waitCnt_reg >= waitSel));
    end
  end

  // ************************************
  // axi4-lite write
  // ************************************
  wire doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

  always @(posedge clk) begin
    if (!nrst) begin
      awAddr_reg <= 4'h0;
      awHeld_reg <= 1'b0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      wHeld_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PBSI_RESP_OK;
      ctrl_reg <= `PBSI_CTRL_RST;
      wait_reg <= `PBSI_WAIT_RST;
    end else begin
      s_axi_awready <= ~awHeld_reg & ~s_axi_awready;
      s_axi_wready <= ~wHeld_reg & ~s_axi_wready;
      if (s_axi_awvalid & s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PBSI_RESP_OK;
        case (awAddr_reg)
          `PBSI_OFF_CTRL: begin
            if (wStrb_reg[0]) begin
              ctrl_reg <= wData_reg[3:0];
            end
          end
          `PBSI_OFF_WAIT: begin
            if (wStrb_reg[0]) begin
              wait_reg[7:0] <= wData_reg[7:0];
            end
            if (wStrb_reg[1]) begin
              wait_reg[15:8] <= wData_reg[15:8];
            end
            if (wStrb_reg[2]) begin
              wait_reg[19:16] <= wData_reg[19:16];
            end
          end
          `PBSI_OFF_STAT: begin
            s_axi_bresp <= `PBSI_RESP_OK;
          end
          default: begin
            s_axi_bresp <= `PBSI_RESP_ERR;
          end
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************
  // axi4-lite read
  // ************************************
  always @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PBSI_RESP_OK;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PBSI_RESP_OK;
        case (s_axi_araddr)
          `PBSI_OFF_CTRL: begin
            s_axi_rdata <= {28'h000_0000, ctrl_reg};
          end
          `PBSI_OFF_WAIT: begin
            s_axi_rdata <= {12'h000, wait_reg};
          end
          `PBSI_OFF_STAT: begin
            s_axi_rdata <= {latchAddr_reg, 12'h000, testing,
              paritySample_reg, bootRomSelect, selfTestDone};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PBSI_RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hw/pbsi_defs.vh
// constants for the processor bus strobe interface
`ifndef PBSI_DEFS_VH
`define PBSI_DEFS_VH
// register byte offsets
`define PBSI_OFF_CTRL 4'h0
`define PBSI_OFF_WAIT 4'h4
`define PBSI_OFF_STAT 4'h8
// control register fields
`define PBSI_CTRL_STRB_FLT 0
`define PBSI_CTRL_ADDR_FLT 1
`define PBSI_CTRL_MMU 2
`define PBSI_CTRL_ODD 3
`define PBSI_CTRL_RST 4'h0
// wait register: four memory fields by extended address, one i/o field
`define PBSI_WAIT_W 4
`define PBSI_WAIT_IO 16
`define PBSI_WAIT_RST 20'h0_0000
// decoded i/o addresses
`define PBSI_IO_IRQ_ACK 16'h1000
`define PBSI_IO_CONF 16'h8410
`define PBSI_IO_SURON 16'h4004
`define PBSI_IO_SUROFF 16'h4005
// self test length in clock cycles
`define PBSI_TEST_CYC 16'h0100
// axi responses
`define PBSI_RESP_OK 2'b00
`define PBSI_RESP_ERR 2'b10
`endif

// ===== tb/pbsi_top_properties.sv
// port checker for the bus strobe interface
`timescale 1ns/1ns
`default_nettype none
`include "pbsi_defs.vh"
module pbsi_top_properties (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // processor bus
  input wire logic [15:0] infoBusIn,
  input wire logic [15:0] infoBusOut,
  input wire logic infoBusOe,
  input wire logic addrLatchStrobe,
  input wire logic dataStrobeN,
  input wire logic memIoSel,
  input wire logic readWriteSel,
  input wire logic [15:0] addrOut,
  // strobes
  input wire logic strobeDriveEnableN,
  input wire logic memWriteStrobeN,
  input wire logic memReadStrobeN,
  input wire logic ioWriteStrobeN,
  input wire logic ioReadStrobeN,
  input wire logic strobeOe,
  input wire logic irqAckStrobeN,
  input wire logic configReadStrobeN,
  // system
  input wire logic extReadyIn,
  input wire logic cycleReady,
  input wire logic testEnableN,
  input wire logic selfTestDone,
  input wire logic [4:0] sysConfigIn
);
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_MEM_WRITE: assert property (!memWriteStrobeN |->
    $past(!dataStrobeN && memIoSel && !readWriteSel)) else $error("bad mw");
  AST_MEM_READ: assert property (!memReadStrobeN |->
    $past(!dataStrobeN && memIoSel && readWriteSel)) else $error("bad mr");
  AST_IO_WRITE: assert property (!ioWriteStrobeN |->
    $past(!dataStrobeN && !memIoSel && !readWriteSel)) else $error("bad iw");
  AST_IO_READ: assert property (!ioReadStrobeN |->
    $past(!dataStrobeN && !memIoSel && readWriteSel)) else $error("bad ir");
  AST_IRQ_ACK: assert property (!irqAckStrobeN |->
    !ioWriteStrobeN && addrOut == `PBSI_IO_IRQ_ACK) else $error("bad ack");
  AST_CONF: assert property (!configReadStrobeN |->
    !ioReadStrobeN && addrOut == `PBSI_IO_CONF) else $error("bad conf");
  AST_INFO_OE: assert property (infoBusOe |->
    $past(!dataStrobeN && readWriteSel && !memIoSel) &&
    infoBusOut[4:0] == $past(sysConfigIn)) else $error("bad bus drive");
  AST_ADDR: assert property ($fell(addrLatchStrobe) |=>
    addrOut == $past(infoBusIn, 2)) else $error("bad address");
  AST_EXT_READY: assert property (!extReadyIn &&
    !$past(extReadyIn) |-> !cycleReady) else $error("ready not held");
  AST_TEST_SKIP: assert property ($rose(nrst) &&
    testEnableN |-> ##[1:2] selfTestDone) else $error("test done late");
  AST_STROBE_OE: assert property (!strobeDriveEnableN &&
    $past(!strobeDriveEnableN) && $past(nrst) |-> strobeOe)
    else $error("strobes not driven");
endmodule
`default_nettype wire

// ===== tb/pbsi_cpu_model.sv
// processor bus master model
`timescale 1ns/1ns
`default_nettype none
module pbsi_cpu_model (
  // clock and device answers
  input wire logic clk,
  input wire logic cycleReady,
  input wire logic [5:0] strobeVec,
  input wire logic [15:0] infoBusOut,
  input wire logic [15:0] addrOe,
  input wire logic infoBusOe,
  input wire logic parityBitLineOe,
  input wire logic parityBitLineOut,
  // processor drive
  output logic [15:0] infoBusIn,
  output logic addrLatchStrobe,
  output logic dataStrobeN,
  output logic memIoSel,
  output logic readWriteSel,
  output logic parityBitLineIn
);
  logic [5:0] lowSeen;
  logic [15:0] rdData, oeSeen;
  logic timedOut = 0;
  logic [1:0] parSeen;
  int waitSeen;
  assign parityBitLineIn = ^infoBusIn;
  initial begin
    infoBusIn = 16'h0000;
    addrLatchStrobe = 0;
    dataStrobeN = 1;
    memIoSel = 0;
    readWriteSel = 1;
  end
  // ****************************************
  // one bus cycle, strobes seen low collected
  // ****************************************
  task automatic cycle(input logic mem, rd, input logic [15:0] a, wd);
    int n;
    @(posedge clk);
    infoBusIn <= a;
    memIoSel <= mem;
    readWriteSel <= rd;
    addrLatchStrobe <= 1;
    @(posedge clk);
    addrLatchStrobe <= 0;
    @(posedge clk);
    // released bus shows the inverse, not a stale value
    infoBusIn <= rd ? ~a : wd;
    dataStrobeN <= 0;
    lowSeen = 0;
    n = 0;
    do begin
      @(posedge clk);
      lowSeen = lowSeen | ~strobeVec;
      n++;
    end while (!cycleReady && n < 300);
    timedOut = timedOut | !cycleReady;
    waitSeen = n;
    rdData = infoBusOe ? infoBusOut : 16'h0000;
    parSeen = {parityBitLineOe, parityBitLineOut};
    oeSeen = addrOe;
    dataStrobeN <= 1;
    infoBusIn <= ~infoBusIn;
    @(posedge clk);
    lowSeen = lowSeen | ~strobeVec;
  endtask
endmodule
`default_nettype wire

// ===== tb/pbsi_top_tb.sv
// testbench of the processor bus strobe interface
`timescale 1ns/1ns
`default_nettype none
`include "pbsi_defs.vh"
module pbsi_top_tb;
  logic [15:0] infoBusIn, infoBusOut, addrOut, addrOe;
  logic clk, nrst, infoBusOe, parityBitLineIn, parityBitLineOut;
  logic parityBitLineOe, addrLatchStrobe, dataStrobeN, memIoSel;
  logic readWriteSel, strobeDriveEnableN, memWriteStrobeN, memReadStrobeN;
  logic ioWriteStrobeN, ioReadStrobeN, strobeOe, irqAckStrobeN;
  logic configReadStrobeN, extReadyIn, cycleReady, testEnableN;
  logic selfTestDone, bootRomSelect;
  logic [1:0] extAddrIn, s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] sysConfigIn;
  logic [5:0] strobeVec;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] kAddr [6] = '{16'h1234, 16'h0abc, 16'h0020, 16'h0021,
    16'h1000, 16'h8410};
  logic [5:0] kExp [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h0a, 6'h05};
  logic [0:5] kMem = 6'h30, kRd = 6'h15;
  int failCount = 0, testsRun = 0, n;
  assign strobeVec = {memWriteStrobeN, memReadStrobeN, ioWriteStrobeN,
    ioReadStrobeN, irqAckStrobeN, configReadStrobeN};
  pbsi_top u_dut (.*);
  pbsi_cpu_model u_cpu (.*);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task check(input string what, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      $display("wrong value %s exp %h seen %h", what, exp, seen);
      failCount++;
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task hang;
    failCount++;
    close_out;
  endtask
  task rst(input logic t);
    nrst <= 0;
    testEnableN <= t;
    repeat (16) @(posedge clk);
    nrst <= 1;
  endtask
  task axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (++n > 99) hang;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task axr(input logic [3:0] a);
    @(posedge clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (++n > 99) hang;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    s_axi_wdata = 0;
    s_axi_wstrb = 4'hf;
    {testEnableN, extReadyIn, strobeDriveEnableN} = 3'h6;
    extAddrIn = 2'h2;
    sysConfigIn = 5'h15;
    rst(1);
    check("boot rom", bootRomSelect, 1);
    check("ready", cycleReady, 0);
    check("strobes", strobeVec, 6'h3f);
    repeat (3) @(posedge clk);
    check("test done", selfTestDone, 1);
    axr(`PBSI_OFF_CTRL);
    check("ctrl", rd, 0);
    axr(`PBSI_OFF_WAIT);
    check("wait", rd, 0);
    axr(4'hc);
    check("bad read", rd, 32'h0000_0000);
    check("bad rresp", resp, 2'h2);
    axw(4'hc, 32'h0000_0001);
    check("bad write", resp, 2'h2);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      u_cpu.cycle(kMem[i], kRd[i], kAddr[i], 16'h5a5a);
      check("strobes", u_cpu.lowSeen, kExp[i]);
      check("address", addrOut, kAddr[i]);
      check("addr drive", u_cpu.oeSeen, 16'hffff);
      check("parity drive", u_cpu.parSeen[1], !kRd[i]);
    end
    check("config", u_cpu.rdData[4:0], 5'h15);
    u_cpu.cycle(0, 0, `PBSI_IO_SUROFF, 0);
    check("rom off", bootRomSelect, 0);
    u_cpu.cycle(0, 0, `PBSI_IO_SURON, 0);
    check("rom on", bootRomSelect, 1);
    $display("test cycles done");
    extReadyIn <= 0;
    fork
      u_cpu.cycle(1, 1, 16'h0100, 0);
      begin
        repeat (8) @(posedge clk);
        check("held ready", cycleReady, 0);
        extReadyIn <= 1;
      end
    join
    $display("test ready done");
    axw(`PBSI_OFF_CTRL, 32'h0000_0003);
    strobeDriveEnableN <= 1;
    repeat (3) @(posedge clk);
    check("float", {strobeOe, addrOe}, 17'h0_0000);
    strobeDriveEnableN <= 0;
    repeat (3) @(posedge clk);
    check("drive", {strobeOe, addrOe}, 17'h1_ffff);
    axw(`PBSI_OFF_CTRL, 32'h0000_0004);
    u_cpu.cycle(1, 0, 16'h0ff0, 16'h0001);
    check("mmu drive", u_cpu.oeSeen, 16'hfff0);
    check("parity", u_cpu.parSeen, 2'b11);
    axw(`PBSI_OFF_WAIT, 32'h0005_0300);
    axr(`PBSI_OFF_WAIT);
    check("wait set", rd, 32'h0005_0300);
    u_cpu.cycle(1, 1, 16'h0ff0, 0);
    check("mmu wait", u_cpu.waitSeen, 5);
    extAddrIn <= 2'h1;
    u_cpu.cycle(1, 1, 16'h0ff0, 0);
    check("mmu no wait", u_cpu.waitSeen, 2);
    u_cpu.cycle(0, 1, 16'h0030, 0);
    check("io wait", u_cpu.waitSeen, 7);
    $display("test float done");
    rst(0);
    repeat (250) @(posedge clk);
    check("test running", selfTestDone, 0);
    n = 0;
    while (!selfTestDone && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("test end", selfTestDone, 1);
    check("no hang", u_cpu.timedOut, 0);
    $display("test self test done");
    close_out;
  end
endmodule
bind pbsi_top pbsi_top_properties u_chk (.*);
`default_nettype wire
